//--- inc/serial_eeprom_pkg.sv
// Constants, state encoding and state record of the serial byte-memory bus slave.
// How it works
// - Data falling while clock high is a start condition opening a transfer.
// - Data rising while clock high is a stop condition ending the transfer.
// - Bus is idle only with both lines high; master starts only then.
// - Transmitter changes data only while clock is low.
// - Any data change during clock high is a control condition, never a bit.
// - One clock pulse per bit; bit sampled on clock rise after a start.
// - Every transfer is framed by a start and a stop.
// - Write transfers accept at most eight data bytes after the word address.
// - Read transfers supply bytes without limit until the master declines.
// - Eight-bit bytes, each followed by an acknowledge on the ninth clock.
// - Works at any bus clock up to 100 kHz, including 2 kHz.
// - Lines are only pulled low or released, never driven high.
// - Chip address comes from three strap inputs; respond only when matched.
// - Address byte is type nibble, three strap bits, then read/write, MSB first.
// - Read/write bit one selects read, zero selects write.
// - After a write stop, run a program cycle of 7 ms per byte; a write that overran the page limit is aborted with no program cycle.
// - During the program cycle the address is not acknowledged.
package serial_eeprom_pkg;

   localparam int unsigned CLK_HZ             = 50_000_000;
   localparam int unsigned PROGRAM_MS         = 7;
   localparam int unsigned PROGRAM_CYCLES_DEF = CLK_HZ / 1000 * PROGRAM_MS;
   localparam int unsigned TIMER_W            = 24;
   localparam int unsigned PAGE_BYTES         = 8;
   localparam logic [3:0]  BYTE_BITS          = 4'h8;
   localparam logic [3:0]  LAST_TX_FALL       = 4'h7;

   typedef logic [TIMER_W-1:0] timer_type;

   typedef enum logic [7:0]
   {
      ST_IDLE   = 8'h01,
      ST_DEV    = 8'h02,
      ST_ACKD   = 8'h04,
      ST_RX     = 8'h08,
      ST_ACKR   = 8'h10,
      ST_TX     = 8'h20,
      ST_MACK   = 8'h40,
      ST_IGNORE = 8'h80
   } state_type;

   typedef struct packed
   {
      logic       scl_m;
      logic       scl_s;
      logic       scl_p;
      logic       sda_m;
      logic       sda_s;
      logic       sda_p;
      logic [2:0] strap_m;
      logic [2:0] strap_s;
      state_type  state;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic       rw;
      logic       wr_sel;
      logic       first;
      logic [3:0] data_cnt;
      logic       overflow;
      logic       push;
      logic       push_first;
      logic       sda_oe;
      logic       busy;
      timer_type  timer;
      logic [3:0] busy_bytes;
      logic       commit;
      logic       abort;
      logic       rd_next;
   } regs_type;

   function automatic logic [7:0] shift_in(input logic [7:0] value, input logic bit_in);
      shift_in = {value[6:0], bit_in};
   endfunction : shift_in

endpackage : serial_eeprom_pkg

//--- inc/byte_buf_if.sv
// Valid/ready carrier between the bus front end and its two-entry byte buffer.
interface byte_buf_if #(parameter int unsigned WIDTH = 9);
   logic             in_valid;
   logic             in_ready;
   logic [WIDTH-1:0] in_data;
   logic             out_valid;
   logic             out_ready;
   logic [WIDTH-1:0] out_data;

   modport feeder (output in_valid, output in_data, input in_ready,
                   input out_valid, input out_data, output out_ready);
   modport store  (input in_valid, input in_data, output in_ready,
                   output out_valid, output out_data, input out_ready);
endinterface : byte_buf_if

//--- verilog/byte_buf2.sv
// Two-entry buffer holding received bytes until the memory side takes them.
module byte_buf2 #(parameter int unsigned WIDTH = 9)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Buffer ports
   byte_buf_if.store bus
);

   typedef struct packed
   {
      logic [WIDTH-1:0] slot0;
      logic [WIDTH-1:0] slot1;
      logic [1:0]       cnt;
   } buf_type;

   buf_type st;
   buf_type next_st;
   logic    do_push;
   logic    do_pop;

   assign bus.in_ready  = (st.cnt != 2'h2);
   assign bus.out_valid = (st.cnt != 2'h0);
   assign bus.out_data  = st.slot0;
   assign do_push       = bus.in_valid & bus.in_ready;
   assign do_pop        = bus.out_valid & bus.out_ready;

   always_comb
   begin
      next_st = st;
      if (do_push && do_pop)
      begin
         if (st.cnt == 2'h1)
            next_st.slot0 = bus.in_data;
         else
         begin
            next_st.slot0 = st.slot1;
            next_st.slot1 = bus.in_data;
         end
      end
      else if (do_pop)
      begin
         next_st.slot0 = st.slot1;
         next_st.cnt   = st.cnt - 2'h1;
      end
      else if (do_push)
      begin
         if (st.cnt == 2'h0)
            next_st.slot0 = bus.in_data;
         else
            next_st.slot1 = bus.in_data;
         next_st.cnt = st.cnt + 2'h1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         st <= '0;
      else
         st <= next_st;
   end

endmodule : byte_buf2

//--- verilog/serial_eeprom_bus_slave.sv
// Two-wire bus slave front end of a small nonvolatile byte memory.
module serial_eeprom_bus_slave
   import serial_eeprom_pkg::*;
#(
   // Device type nibble; the value here is arbitrary.
   parameter logic [3:0]  DEVICE_TYPE    = 4'h5,
   parameter int unsigned PROGRAM_CYCLES = serial_eeprom_pkg::PROGRAM_CYCLES_DEF,
   parameter int unsigned PAGE_LIMIT     = serial_eeprom_pkg::PAGE_BYTES
)
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Two-wire bus pins
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output wire logic       sda_o,
   output wire logic       sda_oe_o,
   // Chip select straps
   input  wire logic       chip_select_strap_0_i,
   input  wire logic       chip_select_strap_1_i,
   input  wire logic       chip_select_strap_2_i,
   // Received byte stream
   output wire logic       wr_valid_o,
   output wire logic [7:0] wr_data_o,
   output wire logic       wr_addr_flag_o,
   input  wire logic       wr_ready_i,
   output wire logic       wr_commit_o,
   output wire logic       wr_abort_o,
   // Read byte source
   input  wire logic [7:0] rd_data_i,
   output wire logic       rd_next_o,
   // Program cycle status
   output wire logic       busy_o
);
   import serial_eeprom_pkg::*;

   regs_type st;
   regs_type next_st;
   logic     scl_rise;
   logic     scl_fall;
   logic     start_seen;
   logic     stop_seen;
   logic     addr_match;

   byte_buf_if #(.WIDTH(9)) buf_bus ();

   byte_buf2 #(.WIDTH(9)) u_buf
   (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .bus     (buf_bus.store)
   );

   // Edges come from the second and third stages only, never the first.
   assign scl_rise   = st.scl_s & ~st.scl_p;
   // Edge detection needs no bit-time constant, so any slow bus rate is followed.
   assign scl_fall   = ~st.scl_s & st.scl_p;
   assign start_seen = st.scl_s & st.scl_p & st.sda_p & ~st.sda_s;
   assign stop_seen  = st.scl_s & st.scl_p & ~st.sda_p & st.sda_s;
   assign addr_match = (st.shift[7:1] == {DEVICE_TYPE, st.strap_s});

   assign buf_bus.in_valid  = st.push;
   assign buf_bus.in_data   = {st.push_first, st.shift};
   assign buf_bus.out_ready = wr_ready_i;

   assign sda_o          = 1'b0;
   assign sda_oe_o       = st.sda_oe;
   assign wr_valid_o     = buf_bus.out_valid;
   assign wr_data_o      = buf_bus.out_data[7:0];
   assign wr_addr_flag_o = buf_bus.out_data[8];
   assign wr_commit_o    = st.commit;
   assign wr_abort_o     = st.abort;
   assign rd_next_o      = st.rd_next;
   assign busy_o         = st.busy;

   always_comb
   begin
      next_st         = st;
      next_st.commit  = 1'b0;
      next_st.abort   = 1'b0;
      next_st.rd_next = 1'b0;
      next_st.push    = 1'b0;
      next_st.scl_m   = scl_i;
      next_st.scl_s   = st.scl_m;
      next_st.scl_p   = st.scl_s;
      next_st.sda_m   = sda_i;
      next_st.sda_s   = st.sda_m;
      next_st.sda_p   = st.sda_s;
      next_st.strap_m = {chip_select_strap_2_i, chip_select_strap_1_i, chip_select_strap_0_i};
      next_st.strap_s = st.strap_m;
      // Program cycle timer, one period per stored byte.
      if (st.busy)
      begin
         if (st.timer == '0)
         begin
            if (st.busy_bytes <= 4'h1)
               next_st.busy = 1'b0;
            else
            begin
               next_st.busy_bytes = st.busy_bytes - 4'h1;
               next_st.timer      = timer_type'(PROGRAM_CYCLES - 1);
            end
         end
         else
            next_st.timer = st.timer - timer_type'(1);
      end
      if (start_seen)
      begin
         next_st.state    = ST_DEV;
         next_st.bit_cnt  = 4'h0;
         next_st.data_cnt = 4'h0;
         next_st.overflow = 1'b0;
         next_st.first    = 1'b1;
         next_st.wr_sel   = 1'b0;
         next_st.sda_oe   = 1'b0;
      end
      else if (stop_seen)
      begin
         next_st.state  = ST_IDLE;
         next_st.sda_oe = 1'b0;
         next_st.wr_sel = 1'b0;
         if (st.wr_sel && st.overflow)
            next_st.abort = 1'b1;
         else if (st.wr_sel && st.data_cnt != 4'h0)
         begin
            next_st.commit     = 1'b1;
            next_st.busy       = 1'b1;
            next_st.busy_bytes = st.data_cnt;
            next_st.timer      = timer_type'(PROGRAM_CYCLES - 1);
         end
      end
      else
      begin
         case (st.state)
            ST_DEV:
            begin
               if (scl_rise)
               begin
                  next_st.shift   = shift_in(st.shift, st.sda_s);
                  next_st.bit_cnt = st.bit_cnt + 4'h1;
               end
               else if (scl_fall && st.bit_cnt == BYTE_BITS)
               begin
                  if (addr_match && !st.busy)
                  begin
                     next_st.state  = ST_ACKD;
                     next_st.sda_oe = 1'b1;
                     next_st.rw     = st.shift[0];
                     next_st.wr_sel = ~st.shift[0];
                  end
                  else
                     next_st.state = ST_IGNORE;
               end
            end
            ST_ACKD:
            begin
               if (scl_fall)
               begin
                  next_st.bit_cnt = 4'h0;
                  if (st.rw)
                  begin
                     next_st.state   = ST_TX;
                     next_st.shift   = rd_data_i;
                     next_st.rd_next = 1'b1;
                     next_st.sda_oe  = ~rd_data_i[7];
                  end
                  else
                  begin
                     next_st.state  = ST_RX;
                     next_st.sda_oe = 1'b0;
                  end
               end
            end
            ST_RX:
            begin
               if (scl_rise)
               begin
                  next_st.shift   = shift_in(st.shift, st.sda_s);
                  next_st.bit_cnt = st.bit_cnt + 4'h1;
               end
               else if (scl_fall && st.bit_cnt == BYTE_BITS)
               begin
                  // No clock stretching exists, so a full buffer can only refuse.
                  if ((!st.first && st.data_cnt == 4'(PAGE_LIMIT)) || !buf_bus.in_ready)
                  begin
                     next_st.overflow = 1'b1;
                     next_st.state    = ST_IGNORE;
                  end
                  else
                  begin
                     next_st.push       = 1'b1;
                     next_st.push_first = st.first;
                     next_st.first      = 1'b0;
                     next_st.data_cnt   = st.data_cnt + {3'h0, ~st.first};
                     next_st.state      = ST_ACKR;
                     next_st.sda_oe     = 1'b1;
                  end
               end
            end
            ST_ACKR:
            begin
               if (scl_fall)
               begin
                  next_st.state   = ST_RX;
                  next_st.sda_oe  = 1'b0;
                  next_st.bit_cnt = 4'h0;
               end
            end
            ST_TX:
            begin
               if (scl_fall)
               begin
                  next_st.bit_cnt = st.bit_cnt + 4'h1;
                  if (st.bit_cnt == LAST_TX_FALL)
                  begin
                     next_st.state   = ST_MACK;
                     next_st.sda_oe  = 1'b0;
                     next_st.bit_cnt = 4'h0;
                  end
                  else
                  begin
                     next_st.shift  = {st.shift[6:0], 1'b0};
                     next_st.sda_oe = ~st.shift[6];
                  end
               end
            end
            ST_MACK:
            begin
               if (scl_rise)
               begin
                  if (st.sda_s)
                     next_st.state = ST_IGNORE;
                  else
                     next_st.bit_cnt = BYTE_BITS;
               end
               else if (scl_fall && st.bit_cnt == BYTE_BITS)
               begin
                  next_st.state   = ST_TX;
                  next_st.shift   = rd_data_i;
                  next_st.rd_next = 1'b1;
                  next_st.sda_oe  = ~rd_data_i[7];
                  next_st.bit_cnt = 4'h0;
               end
            end
            ST_IDLE, ST_IGNORE:
            begin
               next_st.sda_oe = 1'b0;
            end
            default:
            begin
               next_st.state  = ST_IDLE;
               next_st.sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         st       <= '0;
         st.state <= ST_IDLE;
         st.scl_m <= 1'b1;
         st.scl_s <= 1'b1;
         st.scl_p <= 1'b1;
         st.sda_m <= 1'b1;
         st.sda_s <= 1'b1;
         st.sda_p <= 1'b1;
      end
      else
         st <= next_st;
   end

   property p_start;
      @(posedge clk_i) disable iff (!rst_n_i)
         start_seen |=> (st.state == ST_DEV && st.bit_cnt == 4'h0);
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   property p_stop;
      @(posedge clk_i) disable iff (!rst_n_i) stop_seen |=> (st.state == ST_IDLE && !st.sda_oe);
   endproperty
   a_stop: assert property (p_stop) else $error("stop not taken");

   property p_drive_low;
      @(posedge clk_i) disable iff (!rst_n_i)
         sda_oe_o |-> (sda_o == 1'b0 && st.state inside {ST_ACKD, ST_ACKR, ST_TX});
   endproperty
   a_drive_low: assert property (p_drive_low) else $error("line driven high");

   property p_change_low;
      @(posedge clk_i) disable iff (!rst_n_i)
         $changed(sda_oe_o) |-> (!st.scl_s || stop_seen || start_seen);
   endproperty
   a_change_low: assert property (p_change_low) else $error("data moved in clock high");

   property p_match;
      @(posedge clk_i) disable iff (!rst_n_i) (st.state == ST_ACKD) |-> addr_match;
   endproperty
   a_match: assert property (p_match) else $error("ack without address match");

   property p_busy_nack;
      @(posedge clk_i) disable iff (!rst_n_i) st.busy |-> (st.state != ST_ACKD);
   endproperty
   a_busy_nack: assert property (p_busy_nack) else $error("ack during program");

   property p_page;
      @(posedge clk_i) disable iff (!rst_n_i) st.data_cnt <= 4'(PAGE_LIMIT);
   endproperty
   a_page: assert property (p_page) else $error("page limit passed");

   property p_read_dir;
      @(posedge clk_i) disable iff (!rst_n_i)
         (st.state == ST_ACKD && scl_fall && st.rw && !start_seen && !stop_seen)
         |=> (st.state == ST_TX && rd_next_o);
   endproperty
   a_read_dir: assert property (p_read_dir) else $error("read not started");

   property p_commit_busy;
      @(posedge clk_i) disable iff (!rst_n_i)
         wr_commit_o |-> (busy_o && st.busy_bytes == $past(st.data_cnt));
   endproperty
   a_commit_busy: assert property (p_commit_busy) else $error("no program cycle");

endmodule : serial_eeprom_bus_slave

//--- dv/bus_master_model.sv
// Behavioural two-wire bus master that frames transfers towards the slave.
module bus_master_model
(
   // Clock
   input  wire logic clk_i,
   // Resolved data line
   input  wire logic sda_i,
   // Driven clock line and open-drain data line control
   output logic      scl_o,
   output logic      sda_low_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // Clock cycles per quarter bus period; the bench raises it for the slow rate.
   int qn = 2;

   initial
   begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end

   task automatic q();
      repeat (qn) @(negedge clk_i);
   endtask : q

   // The task raises the clock itself, so a start also serves as a repeated start mid-transfer.
   task automatic start();
      sda_low_o = 1'b0;
      q();
      scl_o = 1'b1;
      q();
      sda_low_o = 1'b1;
      q();
      scl_o = 1'b0;
      q();
   endtask : start

   task automatic stop();
      sda_low_o = 1'b1;
      q();
      scl_o = 1'b1;
      q();
      sda_low_o = 1'b0;
      q();
      q();
   endtask : stop

   // Data moves only while the clock is low; the line is read late in the high phase.
   task automatic bit_x(input logic b, output logic s);
      sda_low_o = ~b;
      q();
      scl_o = 1'b1;
      q();
      q();
      s     = sda_i;
      scl_o = 1'b0;
      q();
   endtask : bit_x

   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_x(b[i], s);
      bit_x(1'b1, s);
      ack = ~s;
   endtask : wr_byte

   task automatic rd_byte(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_x(1'b1, b[i]);
      bit_x(nack, s);
   endtask : rd_byte
endmodule : bus_master_model

//--- dv/tb.sv
// Self-checking bench for the two-wire byte-memory bus slave.
module tb;
   timeunit 1ns;
   timeprecision 1ns;

   // Device type nibble; the value is arbitrary.
   localparam logic [3:0]  DEV_TYPE = 4'h9;
   localparam logic [2:0]  STRAP    = 3'h5;
   localparam int unsigned PROG     = 50;

   logic       clk      = 1'b0;
   logic       rst_n    = 1'b0;
   logic       wr_ready = 1'b1;
   logic [2:0] strap    = STRAP;
   logic [7:0] rd_data  = 8'ha5;
   wire        scl;
   wire        m_low;
   wire        sda_oe;
   wire        sda;
   wire        sda_out;
   wire        wr_valid;
   wire  [7:0] wr_data;
   wire        wr_flag;
   wire        commit;
   wire        abort;
   wire        rd_next;
   wire        busy;
   logic [8:0] got[$];
   int         n_commit, n_abort, busy_cyc, cyc;
   int         error_cnt, n_tests;

   always #10 clk = ~clk;

   // The pull-up wins unless a party enables its driver; the slave's driven value is honoured.
   assign sda = ~m_low & (sda_oe ? sda_out : 1'b1);

   serial_eeprom_bus_slave #(.DEVICE_TYPE(DEV_TYPE), .PROGRAM_CYCLES(PROG))
      serial_eeprom_bus_slave_i
   (
      .clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_out),
      .sda_oe_o(sda_oe), .chip_select_strap_0_i(strap[0]),
      .chip_select_strap_1_i(strap[1]), .chip_select_strap_2_i(strap[2]),
      .wr_valid_o(wr_valid), .wr_data_o(wr_data), .wr_addr_flag_o(wr_flag),
      .wr_ready_i(wr_ready), .wr_commit_o(commit), .wr_abort_o(abort),
      .rd_data_i(rd_data), .rd_next_o(rd_next), .busy_o(busy)
   );

   bus_master_model m_i (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

   always @(posedge clk)
   begin
      if (rst_n && wr_valid && wr_ready)
         got.push_back({wr_flag, wr_data});
      if (commit)
         n_commit++;
      if (abort)
         n_abort++;
      if (busy)
         busy_cyc++;
      if (rd_next)
         rd_data <= rd_data + 8'h01;
   end

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   // The ceiling is several times the expected run, so only a hang reaches it.
   always @(negedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   function automatic logic [7:0] dev(input logic rw);
      return {DEV_TYPE, STRAP, rw};
   endfunction : dev

   task automatic wait_idle();
      for (int i = 0; i < 1000 && busy !== 1'b0; i++)
         @(negedge clk);
   endtask : wait_idle

   // Eight data bytes is the last count still accepted; a second access mid-program is refused.
   task automatic t_page_write();
      logic a;
      got.delete();
      n_commit = 0;
      busy_cyc = 0;
      m_i.start();
      m_i.wr_byte(dev(1'b0), a);
      chk(16'(a), 16'h1);
      m_i.wr_byte(8'h38, a);
      chk(16'(a), 16'h1);
      for (int i = 0; i < 8; i++)
      begin
         m_i.wr_byte(8'h40 + 8'(i), a);
         chk(16'(a), 16'h1);
      end
      m_i.stop();
      chk(16'(busy), 16'h1);
      m_i.start();
      m_i.wr_byte(dev(1'b0), a);
      chk(16'(a), 16'h0);
      m_i.stop();
      chk(16'(n_commit), 16'h1);
      chk(16'(got.size()), 16'h9);
      chk(16'(got[0]), 16'h138);
      chk(16'(got[8]), 16'h047);
      wait_idle();
      chk(16'(busy_cyc), 16'(8 * PROG));
   endtask : t_page_write

   task automatic t_overflow();
      logic a;
      n_abort  = 0;
      n_commit = 0;
      m_i.start();
      m_i.wr_byte(dev(1'b0), a);
      m_i.wr_byte(8'h08, a);
      for (int i = 0; i < 9; i++)
      begin
         m_i.wr_byte(8'(i), a);
         chk(16'(a), 16'(i < 8));
      end
      m_i.stop();
      chk(16'(n_abort), 16'h1);
      chk(16'(n_commit), 16'h0);
      chk(16'(busy), 16'h0);
   endtask : t_overflow

   task automatic t_straps();
      logic a;
      for (int s = 0; s < 8; s++)
      begin
         strap = 3'(s);
         repeat (6) @(negedge clk);
         m_i.start();
         m_i.wr_byte(dev(1'b0), a);
         chk(16'(a), 16'(3'(s) == STRAP));
         m_i.stop();
         wait_idle();
      end
      // Restore the matching straps so only the type nibble can cause the refusal.
      strap = STRAP;
      repeat (6) @(negedge clk);
      m_i.start();
      m_i.wr_byte({DEV_TYPE ^ 4'h8, STRAP, 1'b0}, a);
      chk(16'(a), 16'h0);
      m_i.stop();
   endtask : t_straps

   task automatic t_read();
      logic       a;
      logic [7:0] b;
      logic [7:0] base;
      base = rd_data;
      m_i.start();
      m_i.wr_byte(dev(1'b1), a);
      chk(16'(a), 16'h1);
      for (int i = 0; i < 4; i++)
      begin
         m_i.rd_byte(i == 3, b);
         chk(16'(b), 16'(base + 8'(i)));
      end
      m_i.stop();
   endtask : t_read

   // A repeated start right after the word address must restart address reception.
   task automatic t_rep_start();
      logic       a;
      logic [7:0] b;
      logic [7:0] base;
      m_i.start();
      m_i.wr_byte(dev(1'b0), a);
      m_i.wr_byte(8'h10, a);
      base = rd_data;
      m_i.start();
      m_i.wr_byte(dev(1'b1), a);
      chk(16'(a), 16'h1);
      m_i.rd_byte(1'b1, b);
      chk(16'(b), 16'(base));
      m_i.stop();
      wait_idle();
   endtask : t_rep_start

   // The consumer stalls: two bytes fill the buffer, the third is refused and none is lost.
   task automatic t_stall();
      logic a;
      got.delete();
      n_abort  = 0;
      wr_ready = 1'b0;
      m_i.start();
      m_i.wr_byte(dev(1'b0), a);
      for (int i = 0; i < 3; i++)
      begin
         m_i.wr_byte(8'h20 + 8'(i), a);
         chk(16'(a), 16'(i < 2));
      end
      m_i.stop();
      chk(16'(wr_valid), 16'h1);
      wr_ready = 1'b1;
      repeat (6) @(negedge clk);
      chk(16'(got.size()), 16'h2);
      chk(16'(got[1]), 16'h021);
      chk(16'(wr_valid), 16'h0);
      chk(16'(n_abort), 16'h1);
   endtask : t_stall

   task automatic t_slow();
      logic a;
      n_commit = 0;
      m_i.qn   = 20;
      m_i.start();
      m_i.wr_byte(dev(1'b0), a);
      chk(16'(a), 16'h1);
      m_i.wr_byte(8'h55, a);
      m_i.wr_byte(8'hc3, a);
      chk(16'(a), 16'h1);
      m_i.stop();
      chk(16'(n_commit), 16'h1);
      m_i.qn = 2;
      wait_idle();
   endtask : t_slow

   initial
   begin
      repeat (10) @(negedge clk);
      chk(16'({sda_oe, busy, wr_valid}), 16'h0);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      t_page_write();
      t_overflow();
      t_straps();
      t_read();
      t_rep_start();
      t_stall();
      t_slow();
      tally_and_finish();
   end
endmodule : tb
